// File: verilog/spi_ctrl_defs.vh
// constants for the serial controller in spi mode
// assumes inclusion by bare name from the design files
`ifndef SPI_CTRL_DEFS_VH
`define SPI_CTRL_DEFS_VH
`define SPI_MODE_VALUE 2'h2
`define SPI_BUSY_TOKEN 8'hFF
`define SPI_CHAR_BITS 8
`define SPI_FIFO_DEPTH 4
`define SPI_BASE_MHZ 12
`define SPI_CLK_MHZ 100
// system cycles per 12 MHz base tick, rounded down
`define SPI_BASE_DIV (`SPI_CLK_MHZ / `SPI_BASE_MHZ)
`define SPI_MAX_MASTER_MBPS 6
`define SPI_MAX_SLAVE_MBPS 5
`endif

// File: verilog/spi_fifo.v
// small flip-flop fifo used for transmit and receive characters
// assumes single clock, push and pop from same-domain logic
`timescale 1ns/1ps
`default_nettype none
module spi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clock,
  input wire rstn,
  input wire push,
  input wire [WIDTH-1:0] pushData,
  input wire pop,
  output wire [WIDTH-1:0] popData,
  output wire empty,
  output wire full
);
  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire doPush = push && (count != DEPTH[AW:0]);
  wire doPop = pop && (count != {(AW+1){1'b0}});
  assign empty = (count == {(AW+1){1'b0}});
  assign full = (count == DEPTH[AW:0]);
  assign popData = mem[rdPtr];
  // pointer and count update; a push into a full fifo is dropped
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (doPush)
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      if (doPop)
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      if (doPush && !doPop)
        count <= count + 1'b1;
      else if (doPop && !doPush)
        count <= count - 1'b1;
    end
  end
  // entries carry no reset; only the pointers define content
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : gEntry
      always @(posedge clock) begin
        if (doPush && wrPtr == i[AW-1:0])
          mem[i] <= pushData;
      end
    end
  endgenerate
endmodule // spi_fifo
`default_nettype wire

// File: verilog/spi_master_slave_controller.v
// serial controller in spi mode: master and slave shifter, fifos, flags
// assumes the pin inputs are asynchronous and dma/software share the port
`timescale 1ns/1ps
`default_nettype none
`include "spi_ctrl_defs.vh"
module spi_master_slave_controller #(
  parameter RATE_DIV = `SPI_BASE_DIV
) (
  input wire clock,
  input wire rstn,
  input wire [1:0] serialModeReg,
  input wire masterSelectBit,
  input wire i2cAckBit,
  input wire [3:0] rateExponent,
  input wire [3:0] rateLinear,
  input wire clockPolarityBit,
  input wire clockPhaseBit,
  input wire bitOrderBit,
  input wire repeatSelectBit,
  input wire autoRepeatEnable,
  input wire irqTriggerMode,
  input wire dataWrite,
  input wire [7:0] dataWriteValue,
  input wire dataRead,
  output reg [7:0] dataReadValue,
  output wire txReady,
  output wire rxAvailable,
  output reg txIdleFlag,
  output reg txSpaceFlag,
  output wire rxValidFlag,
  output reg rxOverflowFlag,
  input wire rxOverflowClear,
  input wire [1:0] txBufferActive,
  input wire [1:0] rxBufferActive,
  input wire rxDmaChannelReset,
  input wire rxDmaBufferLoad,
  output reg rxDmaError,
  input wire [6:0] irqEnableMask,
  input wire topIrqEnableSet,
  output reg [6:0] irqFlagReg,
  input wire [6:0] irqFlagClear,
  output wire serialIrqLine,
  output reg sclkOut,
  output reg mosiOut,
  input wire misoIn,
  input wire sclkIn,
  input wire mosiIn,
  input wire slaveSelectN,
  output reg misoOut,
  output wire misoOe
);
  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire spiMode = (serialModeReg == `SPI_MODE_VALUE);
  wire masterOn = spiMode && masterSelectBit && i2cAckBit;
  wire slaveOn = spiMode && !masterSelectBit;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg [3:0] pinMeta;
  reg [3:0] pinSync;
  // first stage feeds only the second stage
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= 4'hF;
      pinSync <= 4'hF;
    end else begin
      pinMeta <= {slaveSelectN, sclkIn, mosiIn, misoIn};
      pinSync <= pinMeta;
    end
  end
  wire ssnS = pinSync[3];
  wire sclkS = pinSync[2];
  wire mosiS = pinSync[1];
  wire misoS = pinSync[0];

  // ---------------------------------------------------------------
  // fifos
  // ---------------------------------------------------------------
  wire txEmpty, txFull, rxEmpty, rxFull;
  wire [7:0] txHead, rxHead;
  reg txPop;
  reg rxPush;
  reg [7:0] rxChar;
  wire rxPop = dataRead && !rxEmpty;
  spi_fifo #(.WIDTH(`SPI_CHAR_BITS), .DEPTH(`SPI_FIFO_DEPTH), .AW(2)) txFifo (
    .clock(clock), .rstn(rstn), .push(dataWrite), .pushData(dataWriteValue),
    .pop(txPop), .popData(txHead), .empty(txEmpty), .full(txFull));
  spi_fifo #(.WIDTH(`SPI_CHAR_BITS), .DEPTH(`SPI_FIFO_DEPTH), .AW(2)) rxFifo (
    .clock(clock), .rstn(rstn), .push(rxPush && !rxFull), .pushData(rxChar),
    .pop(rxPop), .popData(rxHead), .empty(rxEmpty), .full(rxFull));
  assign txReady = !txFull;
  assign rxAvailable = !rxEmpty;
  assign rxValidFlag = !rxEmpty;

  // read data is registered; valid the cycle after the pop
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      dataReadValue <= 8'h00;
    else if (rxPop)
      dataReadValue <= rxHead;
  end

  // ---------------------------------------------------------------
  // master bit clock: 12 MHz base tick, then (lin+1)*2^exp divider
  // ---------------------------------------------------------------
  reg mBusy;
  reg [7:0] baseCnt;
  reg [19:0] halfCnt;
  wire baseTick = (baseCnt == RATE_DIV[7:0] - 8'h01);
  // one full sclk period spans (lin+1)<<exp base ticks rounded down to even (at least 2), half per phase
  wire [19:0] periodTicks = {16'h0000, rateLinear} + 20'h00001;
  wire [19:0] fullTicks = periodTicks << rateExponent;
  wire [19:0] halfTicks = (fullTicks >> 1) == 20'h00000 ? 20'h00001 : (fullTicks >> 1);
  wire halfTick = baseTick && (halfCnt >= halfTicks - 20'h00001);
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      baseCnt <= 8'h00;
      halfCnt <= 20'h00000;
    end else if (!masterOn || !mBusy) begin
      baseCnt <= 8'h00;
      halfCnt <= 20'h00000;
    end else begin
      baseCnt <= baseTick ? 8'h00 : baseCnt + 8'h01;
      if (baseTick)
        halfCnt <= halfTick ? 20'h00000 : halfCnt + 20'h00001;
    end
  end

  // ---------------------------------------------------------------
  // master shifter
  // ---------------------------------------------------------------
  reg [7:0] mTx;
  reg [7:0] mRx;
  reg [3:0] mEdges;
  reg [7:0] lastTx;
  reg autoStart;
  wire canAuto = autoRepeatEnable; // software flips this only when idle
  wire [7:0] fillChar = repeatSelectBit ? lastTx : `SPI_BUSY_TOKEN;
  wire [2:0] idxBit = bitOrderBit ? 3'd0 : 3'd7;
  // shift out lsb or msb first; index stays fixed while the character shifts
  wire mOutBit = bitOrderBit ? mTx[0] : mTx[7];
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mBusy <= 1'b0;
      mTx <= 8'h00;
      mRx <= 8'h00;
      mEdges <= 4'h0;
      lastTx <= 8'h00;
      sclkOut <= 1'b0;
      mosiOut <= 1'b0;
      autoStart <= 1'b0;
    end else begin
      autoStart <= 1'b0;
      if (!masterOn) begin
        mBusy <= 1'b0;
        sclkOut <= clockPolarityBit;
      end else if (!mBusy) begin
        sclkOut <= clockPolarityBit;
        if (!txEmpty || canAuto) begin
          mBusy <= 1'b1;
          mEdges <= 4'h0;
          mTx <= txEmpty ? fillChar : txHead;
          lastTx <= txEmpty ? fillChar : txHead;
          autoStart <= txEmpty;
          if (!clockPhaseBit)
            mosiOut <= txEmpty ? fillChar[idxBit] : txHead[idxBit];
        end
      end else if (halfTick) begin
        sclkOut <= ~sclkOut;
        mEdges <= mEdges + 4'h1;
        // leading edge in phase 0 samples; in phase 1 it drives
        if ((mEdges[0] == 1'b0) != clockPhaseBit) begin
          mRx <= bitOrderBit ? {misoS, mRx[7:1]} : {mRx[6:0], misoS};
          mTx <= bitOrderBit ? {1'b0, mTx[7:1]} : {mTx[6:0], 1'b0};
        end else begin
          mosiOut <= mOutBit;
        end
        if (mEdges == 4'hF)
          mBusy <= 1'b0;
      end
    end
  end
  wire mDone = masterOn && mBusy && halfTick && (mEdges == 4'hF);
  // tx pop when a character is loaded into the serializer
  wire mLoad = masterOn && !mBusy && !txEmpty;

  // ---------------------------------------------------------------
  // slave shifter on synchronised pins
  // ---------------------------------------------------------------
  reg sclkPrev, ssnPrev;
  reg [7:0] sTx, sRx;
  reg [2:0] sCnt;
  wire sSel = slaveOn && !ssnS;
  wire sclkRise = sclkS && !sclkPrev;
  wire sclkFall = !sclkS && sclkPrev;
  wire ssnFall = ssnPrev && !ssnS;
  // mode 0/3 sample on rising, 1/2 on falling
  wire sSample = (clockPolarityBit ^ clockPhaseBit) ? sclkFall : sclkRise;
  wire sShift = (clockPolarityBit ^ clockPhaseBit) ? sclkRise : sclkFall;
  wire sDone = sSel && sSample && (sCnt == 3'd7);
  wire sLoad = slaveOn && (ssnFall || sDone) && !txEmpty;
  assign misoOe = sSel;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclkPrev <= 1'b1;
      ssnPrev <= 1'b1;
      sTx <= 8'h00;
      sRx <= 8'h00;
      sCnt <= 3'd0;
      misoOut <= 1'b0;
    end else begin
      sclkPrev <= sclkS;
      ssnPrev <= ssnS;
      if (ssnFall) begin
        sCnt <= 3'd0;
        sRx <= 8'h00;
        sTx <= txEmpty ? `SPI_BUSY_TOKEN : txHead;
        misoOut <= txEmpty ? 1'b1 : txHead[idxBit];
      end else if (sSel) begin
        if (sSample) begin
          sRx <= bitOrderBit ? {mosiS, sRx[7:1]} : {sRx[6:0], mosiS};
          sCnt <= sCnt + 3'd1;
          if (sCnt == 3'd7)
            sTx <= txEmpty ? fillChar : txHead;
        end
        if (sShift)
          misoOut <= bitOrderBit ? sTx[sCnt] : sTx[3'd7 - sCnt];
      end
    end
  end

  // ---------------------------------------------------------------
  // receive capture, overflow and dma error
  // ---------------------------------------------------------------
  wire charDone = mDone || sDone;
  // phase 0 took its eighth sample one edge before the closing edge
  wire [7:0] mRxFinal = !clockPhaseBit ? mRx :
    (bitOrderBit ? {misoS, mRx[7:1]} : {mRx[6:0], misoS});
  wire [7:0] sRxFinal = bitOrderBit ? {mosiS, sRx[7:1]} : {sRx[6:0], mosiS};
  wire [7:0] doneChar = mDone ? mRxFinal : sRxFinal;
  wire overrun = charDone && rxFull;
  reg rxErrPending;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxPush <= 1'b0;
      rxChar <= 8'h00;
      rxOverflowFlag <= 1'b0;
      rxErrPending <= 1'b0;
      rxDmaError <= 1'b0;
      txPop <= 1'b0;
    end else begin
      txPop <= 1'b0;
      if (mLoad || sLoad)
        txPop <= 1'b1;
      rxPush <= charDone && !rxFull;
      if (charDone)
        rxChar <= doneChar;
      // set wins over clear
      if (overrun)
        rxOverflowFlag <= 1'b1;
      else if (rxOverflowClear)
        rxOverflowFlag <= 1'b0;
      if (overrun)
        rxErrPending <= 1'b1;
      else if (rxErrPending && rxEmpty) begin
        rxErrPending <= 1'b0;
        rxDmaError <= 1'b1;
      end
      if (!(rxErrPending && rxEmpty) && (rxDmaChannelReset || rxDmaBufferLoad))
        rxDmaError <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transmit flags
  // ---------------------------------------------------------------
  wire serBusy = mBusy || sSel;
  wire charOut = mDone || sDone;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txIdleFlag <= 1'b1;
      txSpaceFlag <= 1'b1;
    end else begin
      if (dataWrite && txIdleFlag)
        txIdleFlag <= 1'b0;
      else if (txEmpty && !serBusy && !txPop)
        txIdleFlag <= 1'b1;
      if (charOut)
        txSpaceFlag <= 1'b1;
      else if (txFull)
        txSpaceFlag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt events: edge or level of flags, dma buffer falls, overrun, auto-repeat start
  // ---------------------------------------------------------------
  reg [2:0] flagPrev;
  reg [1:0] txActPrev, rxActPrev;
  wire [2:0] flagNow = {rxValidFlag, txSpaceFlag, txIdleFlag};
  wire [2:0] flagEv = irqTriggerMode ? flagNow : (flagNow & ~flagPrev);
  wire [1:0] txBufDone = txActPrev & ~txBufferActive;
  wire [1:0] rxBufDone = rxActPrev & ~rxBufferActive;
  wire [6:0] events = {autoStart, overrun, rxBufDone[0] | rxBufDone[1],
    txBufDone[0] | txBufDone[1], flagEv};
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flagPrev <= 3'b011;
      txActPrev <= 2'b00;
      rxActPrev <= 2'b00;
      irqFlagReg <= 7'h00;
    end else begin
      flagPrev <= flagNow;
      txActPrev <= txBufferActive;
      rxActPrev <= rxBufferActive;
      // set wins over clear per bit
      irqFlagReg <= (irqFlagReg & ~irqFlagClear) | events;
    end
  end
  assign serialIrqLine = topIrqEnableSet && |(irqFlagReg & irqEnableMask);
endmodule // spi_master_slave_controller
`default_nettype wire

// File: test/spi_slave_model.sv
// behavioural spi slave for the master pins, clock mode 0, msb first
// assumes sclk rests low between characters
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  input wire logic [7:0] reply,
  output logic [7:0] rxByte,
  output int frames
);
  logic [7:0] sh = 8'h00;
  int bits = 0;
  logic [2:0] idx = 3'h0;
  initial frames = 0;
  initial rxByte = 8'h00;
  // sample on the leading edge, a whole byte per frame
  always @(posedge sclk) begin
    sh = {sh[6:0], mosi};
    bits++;
    if (bits % 8 == 0) begin
      rxByte = sh;
      frames++;
    end
  end
  // change miso only on the trailing edge, so the synced input has hold time
  always @(negedge sclk) idx <= bits[2:0];
  assign miso = reply[3'h7 - idx];
endmodule // spi_slave_model
`default_nettype wire

// File: test/spi_master_slave_controller_properties.sv
// port-level checks for the spi controller
// assumes bind onto the controller top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_controller_properties (
  input wire logic clock,
  input wire logic rstn,
  input wire logic dataWrite,
  input wire logic txReady,
  input wire logic rxAvailable,
  input wire logic txIdleFlag,
  input wire logic txSpaceFlag,
  input wire logic rxValidFlag,
  input wire logic rxOverflowFlag,
  input wire logic [1:0] txBufferActive,
  input wire logic rxDmaChannelReset,
  input wire logic rxDmaError,
  input wire logic [6:0] irqEnableMask,
  input wire logic topIrqEnableSet,
  input wire logic [6:0] irqFlagReg,
  input wire logic serialIrqLine
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_SPACE_FULL: assert property ($fell(txReady) |-> ##[0:1] !txSpaceFlag)
    else $error("space flag kept on full fifo");
  AST_IDLE_CLR: assert property (dataWrite && txIdleFlag && txReady |-> ##[1:2] !txIdleFlag)
    else $error("idle flag kept after write");
  AST_RXVAL: assert property ($rose(rxValidFlag) |=> irqFlagReg[2])
    else $error("rx valid rise without its event");
  AST_OVR_IRQ: assert property ($rose(rxOverflowFlag) |-> irqFlagReg[5])
    else $error("overrun without its event");
  AST_DMA_ERR: assert property ($rose(rxDmaError) |-> !rxAvailable)
    else $error("dma error before drain");
  AST_DMA_CLR: assert property (rxDmaChannelReset && rxDmaError |=> !rxDmaError)
    else $error("dma error kept after reset");
  AST_DMA_EDGE: assert property ($fell(txBufferActive[0]) |-> ##[1:2] irqFlagReg[3])
    else $error("no buffer done event");
  AST_IRQ_LINE: assert property (serialIrqLine == (topIrqEnableSet && |(irqFlagReg & irqEnableMask)))
    else $error("irq line wrong");
  // main scenarios reached
  cover property ($rose(rxOverflowFlag));
  cover property ($fell(txReady));
  cover property ($rose(irqFlagReg[6]));
endmodule // spi_master_slave_controller_properties
bind spi_master_slave_controller spi_master_slave_controller_properties props (
  .clock(clock), .rstn(rstn), .dataWrite(dataWrite), .txReady(txReady),
  .rxAvailable(rxAvailable), .txIdleFlag(txIdleFlag), .txSpaceFlag(txSpaceFlag),
  .rxValidFlag(rxValidFlag), .rxOverflowFlag(rxOverflowFlag), .txBufferActive(txBufferActive),
  .rxDmaChannelReset(rxDmaChannelReset), .rxDmaError(rxDmaError),
  .irqEnableMask(irqEnableMask), .topIrqEnableSet(topIrqEnableSet),
  .irqFlagReg(irqFlagReg), .serialIrqLine(serialIrqLine));
`default_nettype wire

// File: test/spi_master_slave_controller_tb_top.sv
// self-checking bench for the spi controller in master and slave mode
// assumes the mode 0 slave model on the master pins, RATE_DIV of 4
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_controller_tb_top;
  logic clock = 0, rstn = 0, mst = 1, ack = 0, pol = 0, pha = 0, ord = 0, rpt = 0;
  logic autoOn = 0, trig = 0, wr = 0, rd = 0, ovClr = 0, dmaRst = 0, top = 0;
  logic sSclk = 0, sMosi = 0, ssn = 1;
  logic [1:0] mode = 2'h2, txAct = 2'h0, rxAct = 2'h0;
  logic [3:0] rexp = 4'h0, rlin = 4'h1;
  logic [7:0] wdata = 8'h00, reply = 8'hA5, rdata, slvByte, sm;
  logic [6:0] mask = 7'h00, fClr = 7'h00, flags;
  wire txRdy, rxAv, idle, space, rxVal, ovf, dmaErr, irq, sclk, mosi, miso, mOut, mOe;
  int bad_count = 0, checks_done = 0, cycles = 0, frames, f0, i, per, tRise;
  // base tick divider; the two-stage miso sync needs a half period of 3+ cycles
  localparam int DIV = 4;
  always #5 clock = ~clock;
  spi_master_slave_controller #(.RATE_DIV(DIV)) dut (
    .clock(clock), .rstn(rstn), .serialModeReg(mode), .masterSelectBit(mst),
    .i2cAckBit(ack), .rateExponent(rexp), .rateLinear(rlin), .clockPolarityBit(pol),
    .clockPhaseBit(pha), .bitOrderBit(ord), .repeatSelectBit(rpt), .autoRepeatEnable(autoOn),
    .irqTriggerMode(trig), .dataWrite(wr), .dataWriteValue(wdata), .dataRead(rd),
    .dataReadValue(rdata), .txReady(txRdy), .rxAvailable(rxAv), .txIdleFlag(idle),
    .txSpaceFlag(space), .rxValidFlag(rxVal), .rxOverflowFlag(ovf), .rxOverflowClear(ovClr),
    .txBufferActive(txAct), .rxBufferActive(rxAct), .rxDmaChannelReset(dmaRst),
    .rxDmaBufferLoad(1'b0), .rxDmaError(dmaErr), .irqEnableMask(mask),
    .topIrqEnableSet(top), .irqFlagReg(flags), .irqFlagClear(fClr),
    .serialIrqLine(irq), .sclkOut(sclk), .mosiOut(mosi), .misoIn(miso), .sclkIn(sSclk),
    .mosiIn(sMosi), .slaveSelectN(ssn), .misoOut(mOut), .misoOe(mOe));
  spi_slave_model slave (.sclk(sclk), .mosi(mosi), .miso(miso), .reply(reply),
    .rxByte(slvByte), .frames(frames));
  // sclk period in system cycles, last pair of rising edges
  always @(posedge sclk) begin
    per = int'($time - tRise) / 10;
    tRise = int'($time);
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic put(input logic [7:0] v);
    @(negedge clock) wr = 1;
    wdata = v;
    @(negedge clock) wr = 0;
  endtask
  task automatic get(input logic [7:0] e);
    @(negedge clock) rd = 1;
    @(negedge clock) rd = 0;
    @(negedge clock) chk("read data", e, rdata);
  endtask
  // bounded wait, then room for the rx push to land
  task automatic waitIdle;
    repeat (4) @(negedge clock);
    for (int n = 0; n < 4000 && idle !== 1'b1; n++) @(negedge clock);
    repeat (4) @(negedge clock);
  endtask
  task automatic clrFlags;
    @(negedge clock) fClr = 7'h7F;
    @(negedge clock) fClr = 7'h00;
  endtask
  // external mode 0 master for slave mode; 20 cycles a bit keeps it at 5 Mbps
  task automatic slv(input logic [7:0] v, input int nb, output logic [7:0] m);
    m = 8'h00;
    @(negedge clock) ssn = 0;
    repeat (10) @(negedge clock);
    chk("miso enable", 1, mOe);
    for (int b = 7; b > 7 - nb; b--) begin
      sMosi = v[b];
      repeat (10) @(negedge clock);
      sSclk = 1;
      m = {m[6:0], mOut};
      repeat (10) @(negedge clock);
      sSclk = 0;
    end
    repeat (10) @(negedge clock);
    ssn = 1;
    repeat (10) @(negedge clock);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, about thirty times the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      close_out;
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge clock);
    rstn = 1;
    chk("idle", 1, idle);
    chk("space", 1, space);
    chk("flags", 0, flags);
    f0 = frames;
    put(8'h3C);
    repeat (200) @(negedge clock);
    chk("frames ack low", 8'(f0), 8'(frames));
    ack = 1;
    waitIdle;
    chk("slave byte", 8'h3C, slvByte);
    chk("period", 8'(2 * DIV), 8'(per));
    get(8'hA5);
    chk("idle event", 1, flags[0]);
    $display("test basic done");
    reply = 8'h5A;
    for (i = 0; i < 5; i++) put(8'h10 + 8'(i));
    @(negedge clock);
    chk("space full", 0, space);
    chk("ready full", 0, txRdy);
    waitIdle;
    chk("last byte", 8'h14, slvByte);
    chk("space", 1, space);
    chk("overflow", 1, ovf);
    chk("overrun event", 1, flags[5]);
    for (i = 0; i < 4; i++) get(8'h5A);
    chk("rx valid", 0, rxVal);
    repeat (4) @(negedge clock);
    chk("dma error", 1, dmaErr);
    @(negedge clock) dmaRst = 1;
    @(negedge clock) dmaRst = 0;
    chk("dma error", 0, dmaErr);
    @(negedge clock) ovClr = 1;
    @(negedge clock) ovClr = 0;
    $display("test fill done");
    ord = 1;
    rexp = 4'h1;
    rlin = 4'h2;
    put(8'h01);
    waitIdle;
    chk("lsb first", 8'h80, slvByte);
    chk("period", 8'(6 * DIV), 8'(per));
    get(8'h5A);
    ord = 0;
    rexp = 4'h0;
    rlin = 4'h1;
    $display("test order done");
    for (i = 1; i >= 0; i--) begin
      rpt = i[0];
      clrFlags;
      autoOn = 1;
      f0 = frames;
      for (int n = 0; n < 4000 && frames < f0 + 2; n++) @(negedge clock);
      chk("auto byte", i ? 8'h01 : 8'hFF, slvByte);
      chk("underrun", 1, flags[6]);
      autoOn = 0;
      waitIdle;
      f0 = frames;
      repeat (300) @(negedge clock);
      chk("stopped", 8'(f0), 8'(frames));
      chk("rx kept", 1, rxVal);
      while (rxAv === 1'b1) begin
        @(negedge clock) rd = 1;
        @(negedge clock) rd = 0;
      end
      @(negedge clock) ovClr = 1;
      @(negedge clock) ovClr = 0;
    end
    $display("test repeat done");
    mask = 7'h04;
    @(negedge clock) chk("irq top off", 0, irq);
    top = 1;
    @(negedge clock) chk("irq on", 1, irq);
    clrFlags;
    chk("edge mode", 0, flags[0]);
    trig = 1;
    repeat (3) @(negedge clock);
    chk("level mode", 1, flags[0]);
    trig = 0;
    clrFlags;
    txAct = 2'h3;
    rxAct = 2'h3;
    repeat (3) @(negedge clock);
    txAct = 2'h0;
    rxAct = 2'h0;
    repeat (3) @(negedge clock);
    chk("buffer done", 8'h18, {1'b0, flags} & 8'h18);
    mask = 7'h00;
    @(negedge clock) chk("irq masked", 0, irq);
    $display("test events done");
    mst = 0;
    slv(8'h00, 3, sm);
    put(8'hC3);
    slv(8'h96, 8, sm);
    chk("slave miso", 8'hC3, sm);
    get(8'h96);
    chk("miso enable off", 0, mOe);
    $display("test slave done");
    close_out;
  end
endmodule // spi_master_slave_controller_tb_top
`default_nettype wire
